// ===== pkg/gsic_pkg.sv
/*
 Constants and carrier types of the general purpose pin block: register
 indices, reset values, control bit positions and the software reset timing.
 Assumes a 200 MHz device clock.
*/
`default_nettype none
package gsic_pkg;
	// Register indices; byte address is four times the index
	localparam logic [5:0] IDX_DIR = 6'h0a;
	localparam logic [5:0] IDX_STATE = 6'h0b;
	localparam logic [5:0] IDX_IEN = 6'h0c;
	localparam logic [5:0] IDX_CTRL = 6'h0e;
	// Reset values
	localparam logic [7:0] DIR_RST = 8'h00;
	localparam logic [7:0] STATE_RST = 8'hff;
	localparam logic [7:0] IEN_RST = 8'h00;
	localparam logic [7:0] CTRL_RST = 8'h00;
	// Control bits; bits 7..4 read as zero
	localparam int CTRL_LATCH = 0;
	localparam int CTRL_MODEM_A = 1;
	localparam int CTRL_MODEM_B = 2;
	localparam int CTRL_SRST = 3;
	localparam logic [7:0] CTRL_WR_MASK = 8'h0f;
	// Nibble positions and modem signal positions within a nibble
	localparam int NIB_A_LO = 4;
	localparam int NIB_B_LO = 0;
	localparam int MDM_RI = 3;
	localparam int MDM_CD = 2;
	localparam int MDM_DTR = 1;
	localparam int MDM_DSR = 0;
	// Software reset pulse length
	localparam int CLK_PERIOD_PS = 5000;
	localparam int SRST_TIME_PS = 20000;
	localparam int SRST_CYC_INT = (SRST_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam logic [2:0] SRST_LAST = 3'(SRST_CYC_INT - 1);
	// Modem inputs delivered to one channel
	typedef struct packed {
		logic ring_indicator_n;
		logic carrier_detect_n;
		logic set_ready_n;
	} gsic_modem_in_t;
endpackage
`default_nettype wire

// ===== core/gsic_core.sv
/*
 General purpose pin block: direction, level state, interrupt enable and
 control registers behind a classic Wishbone slave, pin change interrupt,
 modem nibble hand-over and a self-clearing device software reset.
 Assumes pins already synchronous to clk_i and one shared register set
 reached from either channel's address window.
*/
// The Wishbone interface to the registers was decided locally.
// Behaviour
// - Reading the state register returns the level of all eight pins.
// - Writing the state register drives output pins low for 0, high for 1.
// - State register resets to all ones.
// - Interrupt enable register has one bit per pin, resets to zero.
// - Enable bits of a modem-assigned nibble do not produce interrupts.
// - Writing 1 to control bit 3 resets the whole device.
// - Software reset bit clears itself once that reset completes.
// - Control bit 2 hands the low nibble to channel B modem signals.
// - Control bit 1 hands the high nibble to channel A modem signals.
// - Unlatched, an interrupt is withdrawn when the input returns before read.
// - Latched, the interrupt stays and state keeps the causing level until read.
// - Control bits 7..4 are reserved, read zero; control resets to zero.
// - Direction register bit 0 makes a pin input, 1 makes it output.
`timescale 1ns/100ps
`default_nettype none
module gsic_core
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Pins
	input wire logic [7:0] pin_i,
	output logic [7:0] pin_o,
	output logic [7:0] pin_oe_n_o,
	// Modem signals to and from the channels
	input wire logic terminal_ready_chan_a_n_i,
	input wire logic terminal_ready_chan_b_n_i,
	output gsic_pkg::gsic_modem_in_t modem_chan_a_o,
	output gsic_pkg::gsic_modem_in_t modem_chan_b_o,
	// Device events
	output logic pin_irq_o,
	output logic device_reset_o
);
	logic [7:0] dir_r;
	logic [7:0] state_r;
	logic [7:0] ien_r;
	logic [7:0] ctrl_r;
	logic [7:0] ref_r;
	logic [7:0] pend_r;
	logic [7:0] pend_nxt;
	logic [7:0] eff_en;
	logic [7:0] modem_mask;
	logic [7:0] pin_out_nxt;
	logic [7:0] pin_oe_n_nxt;
	logic [31:0] dat_r;
	logic [2:0] srst_cnt_r;
	logic ack_r;
	logic req;
	logic wr;
	logic rd_clr;
	logic srst_done;
	logic lrst;
	logic [5:0] idx;

	// Level reported by a state read
	function automatic logic [7:0] state_view(input logic [7:0] pins, input logic [7:0] refv,
		input logic [7:0] pend, input logic latch);
		state_view = latch ? ((pend & ~refv) | (~pend & pins)) : pins;
	endfunction

	assign idx = adr_i[7:2];
	assign req = cyc_i & stb_i;
	assign wr = req & ack_r & we_i & sel_i[0];
	assign rd_clr = req & ack_r & ~we_i & (idx == gsic_pkg::IDX_STATE);
	assign srst_done = ctrl_r[gsic_pkg::CTRL_SRST] & (srst_cnt_r == gsic_pkg::SRST_LAST);
	assign lrst = rst_i | srst_done;
	assign ack_o = ack_r;
	assign dat_o = dat_r;
	assign device_reset_o = ctrl_r[gsic_pkg::CTRL_SRST];
	assign pin_irq_o = |pend_r;

	// Bus answer, one cycle after request
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ack_r <= 1'b0;
		else
			ack_r <= req & ~ack_r;
	end

	// Read data captured before ack, unmapped reads zero
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			dat_r <= 32'h0000_0000;
		else if (req & ~ack_r & ~we_i)
		begin
			// one register set for all channels
			unique case (idx)
				gsic_pkg::IDX_DIR: dat_r <= {24'h00_0000, dir_r};
				gsic_pkg::IDX_STATE: dat_r <= {24'h00_0000,
					state_view(pin_i, ref_r, pend_r, ctrl_r[gsic_pkg::CTRL_LATCH])};
				gsic_pkg::IDX_IEN: dat_r <= {24'h00_0000, ien_r};
				gsic_pkg::IDX_CTRL: dat_r <= {24'h00_0000, ctrl_r & gsic_pkg::CTRL_WR_MASK};
				default: dat_r <= 32'h0000_0000;
			endcase
		end
	end

	// Direction register
	always_ff @(posedge clk_i)
	begin
		if (lrst)
			dir_r <= gsic_pkg::DIR_RST;
		else if (wr && idx == gsic_pkg::IDX_DIR)
			dir_r <= dat_i[7:0];
	end

	// Output level register
	always_ff @(posedge clk_i)
	begin
		if (lrst)
			state_r <= gsic_pkg::STATE_RST;
		else if (wr && idx == gsic_pkg::IDX_STATE)
			state_r <= dat_i[7:0];
	end

	// Interrupt enable register
	always_ff @(posedge clk_i)
	begin
		if (lrst)
			ien_r <= gsic_pkg::IEN_RST;
		else if (wr && idx == gsic_pkg::IDX_IEN)
			ien_r <= dat_i[7:0];
	end

	// Control register and software reset counter
	always_ff @(posedge clk_i)
	begin
		if (lrst)
			ctrl_r <= gsic_pkg::CTRL_RST;
		else if (wr && idx == gsic_pkg::IDX_CTRL)
			ctrl_r <= (dat_i[7:0] & gsic_pkg::CTRL_WR_MASK) | (ctrl_r & 8'h08);
	end

	always_ff @(posedge clk_i)
	begin
		if (lrst || !ctrl_r[gsic_pkg::CTRL_SRST])
			srst_cnt_r <= 3'h0;
		else
			srst_cnt_r <= srst_cnt_r + 3'h1;
	end

	always_comb
	begin
		modem_mask = 8'h00;
		if (ctrl_r[gsic_pkg::CTRL_MODEM_A])
			modem_mask[gsic_pkg::NIB_A_LO +: 4] = 4'hf;
		if (ctrl_r[gsic_pkg::CTRL_MODEM_B])
			modem_mask[gsic_pkg::NIB_B_LO +: 4] = 4'hf;
		eff_en = ien_r & ~modem_mask & ~dir_r;
	end

	// change on enabled input sets pending
	always_comb
	begin
		pend_nxt = eff_en & ((pin_i ^ ref_r) | ({8{ctrl_r[gsic_pkg::CTRL_LATCH]}} & pend_r));
		if (rd_clr)
			pend_nxt = 8'h00;
	end

	always_ff @(posedge clk_i)
	begin
		if (lrst)
			pend_r <= 8'h00;
		else
			pend_r <= pend_nxt;
	end

	// Reference level renewed by each state read
	always_ff @(posedge clk_i)
	begin
		if (lrst)
			ref_r <= gsic_pkg::STATE_RST;
		else if (rd_clr)
			ref_r <= dat_r[7:0];
	end

	// Pin drive, with modem nibble hand-over
	always_comb
	begin
		pin_out_nxt = state_r;
		pin_oe_n_nxt = ~dir_r;
		if (ctrl_r[gsic_pkg::CTRL_MODEM_A])
		begin
			pin_oe_n_nxt[gsic_pkg::NIB_A_LO +: 4] = 4'hf;
			pin_oe_n_nxt[gsic_pkg::NIB_A_LO + gsic_pkg::MDM_DTR] = 1'b0;
			pin_out_nxt[gsic_pkg::NIB_A_LO + gsic_pkg::MDM_DTR] = terminal_ready_chan_a_n_i;
		end
		if (ctrl_r[gsic_pkg::CTRL_MODEM_B])
		begin
			pin_oe_n_nxt[gsic_pkg::NIB_B_LO +: 4] = 4'hf;
			pin_oe_n_nxt[gsic_pkg::NIB_B_LO + gsic_pkg::MDM_DTR] = 1'b0;
			pin_out_nxt[gsic_pkg::NIB_B_LO + gsic_pkg::MDM_DTR] = terminal_ready_chan_b_n_i;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			pin_o <= gsic_pkg::STATE_RST;
			pin_oe_n_o <= 8'hff;
		end
		else
		begin
			pin_o <= pin_out_nxt;
			pin_oe_n_o <= pin_oe_n_nxt;
		end
	end

	// Modem inputs, inactive high when nibble is plain pins
	always_ff @(posedge clk_i)
	begin
		if (lrst)
		begin
			modem_chan_a_o <= 3'h7;
			modem_chan_b_o <= 3'h7;
		end
		else
		begin
			modem_chan_a_o.ring_indicator_n <= ~ctrl_r[gsic_pkg::CTRL_MODEM_A]
				| pin_i[gsic_pkg::NIB_A_LO + gsic_pkg::MDM_RI];
			modem_chan_a_o.carrier_detect_n <= ~ctrl_r[gsic_pkg::CTRL_MODEM_A]
				| pin_i[gsic_pkg::NIB_A_LO + gsic_pkg::MDM_CD];
			modem_chan_a_o.set_ready_n <= ~ctrl_r[gsic_pkg::CTRL_MODEM_A]
				| pin_i[gsic_pkg::NIB_A_LO + gsic_pkg::MDM_DSR];
			modem_chan_b_o.ring_indicator_n <= ~ctrl_r[gsic_pkg::CTRL_MODEM_B]
				| pin_i[gsic_pkg::NIB_B_LO + gsic_pkg::MDM_RI];
			modem_chan_b_o.carrier_detect_n <= ~ctrl_r[gsic_pkg::CTRL_MODEM_B]
				| pin_i[gsic_pkg::NIB_B_LO + gsic_pkg::MDM_CD];
			modem_chan_b_o.set_ready_n <= ~ctrl_r[gsic_pkg::CTRL_MODEM_B]
				| pin_i[gsic_pkg::NIB_B_LO + gsic_pkg::MDM_DSR];
		end
	end

	// Checks
	a_state_reset_val: assert property (@(posedge clk_i) rst_i |=> state_r == gsic_pkg::STATE_RST)
		else $error("state register not all ones after reset");
	a_ien_reset_val: assert property (@(posedge clk_i) rst_i |=> ien_r == gsic_pkg::IEN_RST)
		else $error("enable register not zero after reset");
	a_srst_self_clear: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(ctrl_r[3]) |-> ctrl_r[3][*4] ##1 !ctrl_r[3])
		else $error("software reset bit did not clear after four cycles");
	a_srst_resets_regs: assert property (@(posedge clk_i) disable iff (rst_i)
		$fell(ctrl_r[3]) |-> (ien_r == 8'h00) && (dir_r == 8'h00) && !$past(device_reset_o, 5))
		else $error("software reset left registers set");
	a_ctrl_reserved_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		ctrl_r[7:4] == 4'h0)
		else $error("reserved control bits set");
	a_pin_drive_out: assert property (@(posedge clk_i) disable iff (rst_i)
		!ctrl_r[1] && !ctrl_r[2] |=> (pin_oe_n_o == ~$past(dir_r)) && (pin_o == $past(state_r)))
		else $error("pin drive does not follow direction and state");
	a_modem_no_irq: assert property (@(posedge clk_i) disable iff (lrst)
		ctrl_r[1] ##1 ctrl_r[1] |-> pend_r[7:4] == 4'h0)
		else $error("modem nibble raised a pin interrupt");
	a_unlatch_withdraw: assert property (@(posedge clk_i) disable iff (lrst)
		!ctrl_r[0] && pin_i == ref_r |=> pend_r == 8'h00)
		else $error("unlatched interrupt not withdrawn");
	a_latch_hold_pend: assert property (@(posedge clk_i) disable iff (lrst)
		ctrl_r[0] && !rd_clr |=> (pend_r & $past(pend_r & eff_en)) == $past(pend_r & eff_en))
		else $error("latched interrupt lost before read");
	a_read_clears_pend: assert property (@(posedge clk_i) disable iff (lrst)
		rd_clr |=> pend_r == 8'h00 ##1 ref_r == $past(dat_r[7:0], 2))
		else $error("state read did not clear pending");
	a_state_read_pins: assert property (@(posedge clk_i) disable iff (lrst)
		req && !ack_r && !we_i && idx == gsic_pkg::IDX_STATE && !ctrl_r[0] |=> dat_o[7:0] == $past(pin_i))
		else $error("state read does not return pin levels");
endmodule
`default_nettype wire

// ===== sim/gsic_pin_partner.sv
/*
 Far side of the general purpose pins: external drivers on each pin.
 Assumes the device wins a pin while its active-low enable is low.
*/
`timescale 1ns/100ps
`default_nettype none
module gsic_pin_partner
(
	// Device side
	input wire logic [7:0] pin_o,
	input wire logic [7:0] pin_oe_n_o,
	// External drive
	input wire logic [7:0] ext_i,
	output logic [7:0] pin_i
);
	assign pin_i = (~pin_oe_n_o & pin_o) | (pin_oe_n_o & ext_i);
endmodule
`default_nettype wire

// ===== sim/gsic_core_tb.sv
/*
 Register-level bench of the pin block over classic Wishbone.
 Assumes a single-cycle-answer slave and pins resolved by the partner.
*/
`timescale 1ns/100ps
`default_nettype none
module gsic_core_tb;
	logic clk_i, rst_i, cyc_i, stb_i, we_i, ta_n, tb_n;
	logic [7:0] adr_i, ext, pin_i, pin_o, pin_oe_n_o, q;
	logic [3:0] sel_i;
	logic [31:0] dat_i, dat_o;
	logic ack_o, pin_irq_o, device_reset_o;
	gsic_pkg::gsic_modem_in_t mda, mdb;
	int n_fail, samples_checked, cyc_cnt, k;
	gsic_core DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.pin_i(pin_i), .pin_o(pin_o), .pin_oe_n_o(pin_oe_n_o),
		.terminal_ready_chan_a_n_i(ta_n), .terminal_ready_chan_b_n_i(tb_n),
		.modem_chan_a_o(mda), .modem_chan_b_o(mdb), .pin_irq_o(pin_irq_o),
		.device_reset_o(device_reset_o));
	gsic_pin_partner PART (.pin_o(pin_o), .pin_oe_n_o(pin_oe_n_o), .ext_i(ext), .pin_i(pin_i));
	initial
	begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	task automatic print_verdict();
		if (n_fail == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		samples_checked++;
		if (g !== e)
		begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// One classic cycle; ack and data are taken at the ack edge
	task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= {24'h000000, d};
		sel_i <= 4'h1;
		do @(posedge clk_i); while (ack_o !== 1'b1);
		q = dat_o[7:0];
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
		wb(1'b0, a, 8'h00);
		chk(nm, e, q);
	endtask
	task automatic wt(int n);
		repeat (n) @(posedge clk_i);
	endtask
	always @(posedge clk_i)
	begin
		cyc_cnt++;
		if (cyc_cnt >= 5000)
		begin
			n_fail++;
			print_verdict();
		end
	end
	initial
	begin
		{cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} = '0;
		rst_i = 1'b1;
		ext = 8'hff;
		ta_n = 1'b1;
		tb_n = 1'b1;
		n_fail = 0;
		samples_checked = 0;
		cyc_cnt = 0;
		wt(4);
		rst_i <= 1'b0;
		rd(8'h2c, 8'hff, "state");
		rd(8'h30, 8'h00, "ien");
		rd(8'h38, 8'h00, "ctrl");
		rd(8'h28, 8'h00, "dir");
		rd(8'h3c, 8'h00, "unmapped");
		wb(1'b1, 8'h38, 8'hf7);
		rd(8'h38, 8'h07, "ctrl_rsvd");
		wb(1'b1, 8'h38, 8'h00);
		wb(1'b1, 8'h30, 8'hff);
		rd(8'h30, 8'hff, "ien_wr");
		ext <= 8'hfe;
		wt(3);
		chk("irq_rise", 8'h01, {7'h00, pin_irq_o});
		ext <= 8'hff;
		wt(3);
		chk("irq_unlatch", 8'h00, {7'h00, pin_irq_o});
		wb(1'b1, 8'h38, 8'h01);
		ext <= 8'hfe;
		wt(3);
		ext <= 8'hff;
		wt(3);
		chk("irq_latch", 8'h01, {7'h00, pin_irq_o});
		rd(8'h2c, 8'hfe, "state_latch");
		wt(3);
		rd(8'h2c, 8'hff, "state_reread");
		wt(3);
		chk("irq_clear", 8'h00, {7'h00, pin_irq_o});
		wb(1'b1, 8'h38, 8'h02);
		ext <= 8'h6f;
		ta_n <= 1'b0;
		wt(3);
		chk("ri_a", 8'h00, {7'h00, mda.ring_indicator_n});
		chk("cd_a", 8'h01, {7'h00, mda.carrier_detect_n});
		chk("dsr_a", 8'h00, {7'h00, mda.set_ready_n});
		chk("dtr_a", 8'h00, {7'h00, pin_oe_n_o[5]});
		chk("dtr_a_lvl", 8'h00, {7'h00, pin_o[5]});
		chk("irq_mdm_a", 8'h00, {7'h00, pin_irq_o});
		ext <= 8'hff;
		ta_n <= 1'b1;
		wt(2);
		wb(1'b1, 8'h38, 8'h04);
		ext <= 8'hf4;
		tb_n <= 1'b0;
		wt(3);
		chk("ri_b", 8'h00, {7'h00, mdb.ring_indicator_n});
		chk("cd_b", 8'h01, {7'h00, mdb.carrier_detect_n});
		chk("dsr_b", 8'h00, {7'h00, mdb.set_ready_n});
		chk("dtr_b", 8'h00, {7'h00, pin_oe_n_o[1]});
		chk("dtr_b_lvl", 8'h00, {7'h00, pin_o[1]});
		chk("mdm_a_idle", 8'h07, {5'h00, mda});
		chk("irq_mdm_b", 8'h00, {7'h00, pin_irq_o});
		ext <= 8'hff;
		tb_n <= 1'b1;
		wt(2);
		wb(1'b1, 8'h38, 8'h00);
		wb(1'b1, 8'h30, 8'h00);
		wb(1'b1, 8'h28, 8'h0f);
		wb(1'b1, 8'h2c, 8'h5a);
		wt(2);
		chk("oe_n", 8'hf0, pin_oe_n_o);
		chk("pin_o", 8'h0a, {4'h0, pin_o[3:0]});
		rd(8'h2c, 8'hfa, "state_pins");
		wb(1'b1, 8'h30, 8'h5a);
		wb(1'b1, 8'h38, 8'h08);
		k = 0;
		repeat (8)
		begin
			@(posedge clk_i);
			if (device_reset_o === 1'b1)
				k++;
		end
		chk("srst_len", 8'h04, 8'(k));
		rd(8'h38, 8'h00, "srst_self");
		rd(8'h28, 8'h00, "dir_srst");
		rd(8'h30, 8'h00, "ien_srst");
		rd(8'h2c, 8'hff, "state_srst");
		chk("oe_srst", 8'hff, pin_oe_n_o);
		print_verdict();
	end
endmodule
`default_nettype wire
